// [rtl/esm_pkg.sv]
// Package with the register map, field positions and frame constants of the spare bit register set.
package esm_pkg;

    typedef logic [7:0] esm_byte_t;

    // Receive registers, one byte each, indexed from the first receive offset.
    localparam logic [7:0] RX_INTL_ALIGN_OFS    = 8'hc8;
    localparam logic [7:0] RX_INTL_NONALIGN_OFS = 8'hc9;
    localparam logic [7:0] RX_REMOTE_ALARM_OFS  = 8'hca;
    localparam logic [7:0] RX_SPARE4_OFS        = 8'hcb;
    localparam logic [7:0] RX_SPARE5_OFS        = 8'hcc;
    localparam logic [7:0] RX_SPARE6_OFS        = 8'hcd;
    localparam logic [7:0] RX_SPARE7_OFS        = 8'hce;
    localparam logic [7:0] RX_SPARE8_OFS        = 8'hcf;
    localparam int         RX_REG_NUM           = 8;

    // Transmit registers followed by the insertion control byte.
    localparam logic [7:0] TX_INTL_ALIGN_OFS    = 8'hd2;
    localparam logic [7:0] TX_INTL_NONALIGN_OFS = 8'hd3;
    localparam logic [7:0] TX_REMOTE_ALARM_OFS  = 8'hd4;
    localparam logic [7:0] TX_SPARE4_OFS        = 8'hd5;
    localparam logic [7:0] TX_SPARE5_OFS        = 8'hd6;
    localparam logic [7:0] TX_SPARE6_OFS        = 8'hd7;
    localparam logic [7:0] TX_SPARE7_OFS        = 8'hd8;
    localparam logic [7:0] TX_SPARE8_OFS        = 8'hd9;
    localparam logic [7:0] TX_INSERT_CTRL_OFS   = 8'hda;
    localparam int         TX_REG_NUM           = 9;
    localparam int         TX_DATA_NUM          = 8;

    // Group index k: 0 Si align, 1 Si nonalign, 2 alarm, 3..7 Sa4..Sa8.
    localparam int GRP_INTL_ALIGN    = 0;
    localparam int GRP_INTL_NONALIGN = 1;

    // Insertion control bit of group k sits at bit (7 - k).
    localparam int INTL_ALIGN_INSERT_BIT    = 7;
    localparam int INTL_NONALIGN_INSERT_BIT = 6;
    localparam int REMOTE_ALARM_INSERT_BIT  = 5;
    localparam int SPARE4_INSERT_BIT        = 4;
    localparam int SPARE8_INSERT_BIT        = 0;

    // Timeslot 0 layout: Si in bit 7, alarm in bit 5, Sa4..Sa8 in bits 4..0.
    localparam int TS0_INTL_BIT = 7;

    localparam esm_byte_t REG_RESET     = 8'h00;
    localparam logic [3:0] FRAME_FIRST  = 4'h0;
    localparam logic [3:0] FRAME_LAST   = 4'hf;

    // Host service window after each multiframe flag.
    localparam int MF_WINDOW_US = 2000;

endpackage

// [rtl/esm_regs.sv]
// Multiframe Si, alarm and Sa overhead register set with host port and framer hooks.
//
// Function
// - Receive Sa6 odd frames 1..15 read-only at CDh, frame 15 in bit 0.
// - Receive Sa7 odd frames read-only at CEh, frame 1 in MSB.
// - Receive Sa8 odd frames read-only at CFh, frame 1 in bit 7.
// - Writable byte D2h supplies Si of even frames, frame 0 in bit 7.
// - Writable byte D3h supplies Si of odd frames, frame 1 in bit 7.
// - Writable byte D4h supplies remote alarm of odd frames, frame 1 in bit 7.
// - Writable bytes D5h..D9h supply Sa4..Sa8 of odd frames, frame 1 in bit 7.
// - Control bit 0 set inserts Sa8 byte; clear leaves Sa8 alone.
// - Control bit 1 enables Sa7 insertion.
// - Control bit 2 enables Sa6 insertion.
// - Control bit 3 enables Sa5 insertion.
// - Control bit 4 enables Sa4 insertion.
// - Control bit 5 enables remote alarm insertion.
// - Control bit 6 enables Si insertion in nonalign frames.
// - Control bit 7 enables Si insertion in align frames.
// - Receive registers refresh with the receive multiframe flag; host has 2 ms.
// - Transmit registers sampled with transmit multiframe flag; late updates resend old data.
// - Receive registers hold the earliest received bit in the MSB.
// - Transmit registers send the MSB first.
`timescale 1ns/1ps
`default_nettype none
module esm_regs
    import esm_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       sys_rst_i,
    // Host port, one access per strobe cycle.
    input  wire logic [7:0] host_addr_i,
    input  wire logic       host_wr_i,
    input  wire logic       host_rd_i,
    input  wire logic [7:0] host_wdata_i,
    output logic      [7:0] host_rdata_o,
    output logic            host_rvalid_o,
    // Receive framer: timeslot 0 byte of each frame with its multiframe position.
    input  wire logic       rx_ts0_valid_i,
    input  wire logic [3:0] rx_frame_num_i,
    input  wire logic [7:0] rx_ts0_i,
    output logic            rx_multiframe_flag_o,
    // Transmit framer: request for timeslot 0 of a frame, ordinary byte supplied.
    input  wire logic       tx_ts0_req_i,
    input  wire logic [3:0] tx_frame_num_i,
    input  wire logic [7:0] tx_ts0_base_i,
    output logic      [7:0] tx_ts0_o,
    output logic            tx_ts0_valid_o,
    output logic            tx_multiframe_flag_o
);

    // Receive storage: collecting bytes and the host-visible copies.
    esm_byte_t rx_shadow_r [RX_REG_NUM];
    esm_byte_t rx_shadow_nxt [RX_REG_NUM];
    esm_byte_t rx_regs_r [RX_REG_NUM];
    esm_byte_t rx_regs_nxt [RX_REG_NUM];
    logic      rx_mf_flag_r;
    logic      rx_mf_flag_nxt;

    // Transmit storage: host registers and the copy taken at the multiframe start.
    esm_byte_t tx_regs_r [TX_REG_NUM];
    esm_byte_t tx_regs_nxt [TX_REG_NUM];
    esm_byte_t tx_sample_r [TX_DATA_NUM];
    esm_byte_t tx_sample_nxt [TX_DATA_NUM];
    logic      tx_mf_flag_r;
    logic      tx_mf_flag_nxt;
    logic [7:0] tx_ts0_r;
    logic [7:0] tx_ts0_nxt;
    logic       tx_ts0_valid_r;
    logic       tx_ts0_valid_nxt;

    // Host read path.
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       rvalid_r;
    logic       rvalid_nxt;

    logic [63:0] tx_bits_flat;
    logic [7:0]  tx_ts0_ins;
    logic [2:0]  rx_bit_pos;
    logic        tx_mf_start;

    // Address decode shared by the write and read paths.
    logic        wr_tx_hit;
    logic        rd_rx_hit;
    logic        rd_tx_hit;

    // Offsets relative to the start of each register window.
    logic [3:0]  tx_idx;
    logic [2:0]  rx_idx;

    // Live insertion control byte, not sampled per multiframe.
    logic [7:0]  insert_ctrl;

    // True when the address falls in the window [base, base + num).
    function automatic logic addr_in(input logic [7:0] addr, input logic [7:0] base, input int num);
        logic [8:0] top;
        top = 9'(base) + 9'(num);
        return (9'(addr) >= 9'(base)) && (9'(addr) < top);
    endfunction

    // Index of the register inside its window.
    function automatic int addr_idx(input logic [7:0] addr, input logic [7:0] base);
        return int'(addr) - int'(base);
    endfunction

    // Each frame lands at position 7 - f/2, so the earliest frame fills the MSB.
    assign rx_bit_pos  = 3'(7 - int'(rx_frame_num_i[3:1]));
    assign tx_mf_start = tx_ts0_req_i && (tx_frame_num_i == FRAME_FIRST);

    // Each access acts only on a window hit, so the narrow indices stay in range.
    assign wr_tx_hit   = host_wr_i && addr_in(host_addr_i, TX_INTL_ALIGN_OFS, TX_REG_NUM);
    assign rd_rx_hit   = host_rd_i && addr_in(host_addr_i, RX_INTL_ALIGN_OFS, RX_REG_NUM);
    assign rd_tx_hit   = host_rd_i && addr_in(host_addr_i, TX_INTL_ALIGN_OFS, TX_REG_NUM);
    assign tx_idx      = 4'(addr_idx(host_addr_i, TX_INTL_ALIGN_OFS));
    assign rx_idx      = 3'(addr_idx(host_addr_i, RX_INTL_ALIGN_OFS));
    assign insert_ctrl = tx_regs_r[TX_REG_NUM - 1];

    // Receive capture and multiframe refresh.
    always_comb
    begin
        rx_shadow_nxt  = rx_shadow_r;
        rx_regs_nxt    = rx_regs_r;
        rx_mf_flag_nxt = 1'b0;
        // A frame that never arrives leaves its shadow bits from the previous multiframe.
        if (rx_ts0_valid_i)
        begin
            if (!rx_frame_num_i[0])
            begin
                rx_shadow_nxt[GRP_INTL_ALIGN][rx_bit_pos] = rx_ts0_i[TS0_INTL_BIT];
            end
            else
            begin
                rx_shadow_nxt[GRP_INTL_NONALIGN][rx_bit_pos] = rx_ts0_i[TS0_INTL_BIT];
                for (int k = 2; k < RX_REG_NUM; k++)
                begin
                    rx_shadow_nxt[k][rx_bit_pos] = rx_ts0_i[7 - k];
                end
            end
            // The last frame completes the multiframe: publish and raise the flag together.
            if (rx_frame_num_i == FRAME_LAST)
            begin
                rx_regs_nxt    = rx_shadow_nxt;
                rx_mf_flag_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            for (int i = 0; i < RX_REG_NUM; i++)
            begin
                rx_shadow_r[i] <= REG_RESET;
                rx_regs_r[i]   <= REG_RESET;
            end
            rx_mf_flag_r <= 1'b0;
        end
        else
        begin
            rx_shadow_r  <= rx_shadow_nxt;
            rx_regs_r    <= rx_regs_nxt;
            rx_mf_flag_r <= rx_mf_flag_nxt;
        end
    end

    // Host writes and the transmit sample taken at frame 0.
    always_comb
    begin
        tx_regs_nxt    = tx_regs_r;
        tx_sample_nxt  = tx_sample_r;
        tx_mf_flag_nxt = 1'b0;
        // Writes to the receive window or to unmapped offsets change nothing.
        if (wr_tx_hit)
        begin
            tx_regs_nxt[tx_idx] = host_wdata_i;
        end
        // A write in the sampling cycle misses this multiframe; the old value is sent.
        if (tx_mf_start)
        begin
            // Only the eight data bytes are sampled; the control byte stays live.
            for (int k = 0; k < TX_DATA_NUM; k++)
            begin
                tx_sample_nxt[k] = tx_regs_r[k];
            end
            tx_mf_flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            for (int i = 0; i < TX_REG_NUM; i++)
            begin
                tx_regs_r[i] <= REG_RESET;
            end
            for (int i = 0; i < TX_DATA_NUM; i++)
            begin
                tx_sample_r[i] <= REG_RESET;
            end
            tx_mf_flag_r <= 1'b0;
        end
        else
        begin
            tx_regs_r    <= tx_regs_nxt;
            tx_sample_r  <= tx_sample_nxt;
            tx_mf_flag_r <= tx_mf_flag_nxt;
        end
    end

    // Frame 0 uses the registers directly since the sample lands only at the next edge.
    // Later frames read the sample, so host writes after frame 0 wait for the next multiframe.
    genvar g;
    generate
        for (g = 0; g < TX_DATA_NUM; g++)
        begin : g_flat
            assign tx_bits_flat[g*8 +: 8] = tx_mf_start ? tx_regs_r[g] : tx_sample_r[g];
        end
    endgenerate

    esm_tx_insert u_insert (
        .frame_num_i   (tx_frame_num_i),
        .base_ts0_i    (tx_ts0_base_i),
        .tx_bits_i     (tx_bits_flat),
        .insert_ctrl_i (insert_ctrl),
        .ts0_o         (tx_ts0_ins)
    );

    // Outgoing timeslot 0 byte, one cycle after the request.
    always_comb
    begin
        tx_ts0_nxt       = tx_ts0_r;
        tx_ts0_valid_nxt = tx_ts0_req_i;
        // A control byte write applies from the next requested frame.
        if (tx_ts0_req_i)
        begin
            tx_ts0_nxt = tx_ts0_ins;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            tx_ts0_r       <= 8'h00;
            tx_ts0_valid_r <= 1'b0;
        end
        else
        begin
            tx_ts0_r       <= tx_ts0_nxt;
            tx_ts0_valid_r <= tx_ts0_valid_nxt;
        end
    end

    // Host read: registered data one cycle after the strobe, unmapped reads give zero.
    // A read and a write in one cycle return the value from before the write.
    always_comb
    begin
        rdata_nxt  = rdata_r;
        rvalid_nxt = host_rd_i;
        if (host_rd_i)
        begin
            if (rd_rx_hit)
            begin
                rdata_nxt = rx_regs_r[rx_idx];
            end
            else if (rd_tx_hit)
            begin
                rdata_nxt = tx_regs_r[tx_idx];
            end
            else
            begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // Every output comes straight from a register.
    assign host_rdata_o         = rdata_r;
    assign host_rvalid_o        = rvalid_r;
    assign rx_multiframe_flag_o = rx_mf_flag_r;
    assign tx_multiframe_flag_o = tx_mf_flag_r;
    assign tx_ts0_o             = tx_ts0_r;
    assign tx_ts0_valid_o       = tx_ts0_valid_r;

endmodule
`default_nettype wire

// [rtl/esm_tx_insert.sv]
// Overhead bit substitution for one outgoing timeslot 0 byte.
`timescale 1ns/1ps
`default_nettype none
module esm_tx_insert
    import esm_pkg::*;
(
    input  wire logic [3:0]  frame_num_i,
    input  wire logic [7:0]  base_ts0_i,
    input  wire logic [63:0] tx_bits_i,
    input  wire logic [7:0]  insert_ctrl_i,
    output logic      [7:0]  ts0_o
);

    logic [2:0] bit_pos;
    logic       odd_frame;

    // Frame f carries the bit at position 7 - f/2, so the first frame lands in the MSB.
    assign bit_pos   = 3'(7 - int'(frame_num_i[3:1]));
    assign odd_frame = frame_num_i[0];

    always_comb
    begin
        ts0_o = base_ts0_i;
        if (!odd_frame)
        begin
            if (insert_ctrl_i[INTL_ALIGN_INSERT_BIT])
            begin
                ts0_o[TS0_INTL_BIT] = tx_bits_i[GRP_INTL_ALIGN*8 + int'(bit_pos)];
            end
        end
        else
        begin
            if (insert_ctrl_i[INTL_NONALIGN_INSERT_BIT])
            begin
                ts0_o[TS0_INTL_BIT] = tx_bits_i[GRP_INTL_NONALIGN*8 + int'(bit_pos)];
            end
            // Groups 2..7 (alarm, Sa4..Sa8) map onto ts0 bits 5..0 and control bits 5..0.
            for (int k = 2; k < TX_DATA_NUM; k++)
            begin
                if (insert_ctrl_i[7 - k])
                begin
                    ts0_o[7 - k] = tx_bits_i[k*8 + int'(bit_pos)];
                end
            end
        end
    end

endmodule
`default_nettype wire

// [tb/esm_host_model.sv]
// Host processor model on the register port of the spare bit register set.
`timescale 1ns/1ps
`default_nettype none
module esm_host_model
(
    input  wire logic       clk_sys_i,
    output logic      [7:0] host_addr_o,
    output logic            host_wr_o,
    output logic            host_rd_o,
    output logic      [7:0] host_wdata_o,
    input  wire logic [7:0] host_rdata_i,
    input  wire logic       host_rvalid_i
);
    initial
    begin
        host_addr_o = 8'h00;
        host_wr_o = 1'b0;
        host_rd_o = 1'b0;
        host_wdata_o = 8'h00;
    end
    // Between accesses the address shows its inverted value; the data is inverted only after a write.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        host_addr_o = a;
        host_wdata_o = d;
        host_wr_o = 1'b1;
        @(negedge clk_sys_i);
        host_wr_o = 1'b0;
        host_addr_o = ~a;
        host_wdata_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk_sys_i);
        host_addr_o = a;
        host_rd_o = 1'b1;
        @(negedge clk_sys_i);
        host_rd_o = 1'b0;
        host_addr_o = ~a;
        d = host_rdata_i;
        v = host_rvalid_i;
    endtask
endmodule
`default_nettype wire

// [tb/esm_regs_checker.sv]
// Concurrent assertions on the ports of the spare bit register set.
`timescale 1ns/1ps
`default_nettype none
module esm_regs_checker
    import esm_pkg::*;
(
    input wire logic       clk_sys_i,
    input wire logic       sys_rst_i,
    input wire logic [7:0] host_addr_i,
    input wire logic       host_wr_i,
    input wire logic       host_rd_i,
    input wire logic [7:0] host_wdata_i,
    input wire logic [7:0] host_rdata_o,
    input wire logic       host_rvalid_o,
    input wire logic       rx_ts0_valid_i,
    input wire logic [3:0] rx_frame_num_i,
    input wire logic       rx_multiframe_flag_o,
    input wire logic       tx_ts0_req_i,
    input wire logic [3:0] tx_frame_num_i,
    input wire logic [7:0] tx_ts0_base_i,
    input wire logic [7:0] tx_ts0_o,
    input wire logic       tx_ts0_valid_o,
    input wire logic       tx_multiframe_flag_o
);
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] keep;
    // Mirror of the insertion control byte; keep marks bits that must pass the ordinary byte.
    always_comb ctrl_nxt = (host_wr_i && host_addr_i == TX_INSERT_CTRL_OFS) ? host_wdata_i : ctrl_r;
    always_ff @(posedge clk_sys_i) ctrl_r <= sys_rst_i ? REG_RESET : ctrl_nxt;
    assign keep = tx_frame_num_i[0] ? ~{ctrl_r[6], 1'b0, ctrl_r[5:0]} : ~{ctrl_r[7], 7'h00};
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    read_answer_a: assert property (host_rd_i |=> host_rvalid_o) else $error("read not answered");
    read_quiet_a: assert property (!host_rd_i |=> !host_rvalid_o && $stable(host_rdata_o))
        else $error("read answer without read");
    unmapped_read_a: assert property (host_rd_i && host_addr_i == 8'hdf |=> host_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    rx_publish_a: assert property (rx_ts0_valid_i && rx_frame_num_i == FRAME_LAST |=> rx_multiframe_flag_o)
        else $error("receive flag missing");
    rx_quiet_a: assert property (!(rx_ts0_valid_i && rx_frame_num_i == FRAME_LAST) |=> !rx_multiframe_flag_o)
        else $error("receive flag without last frame");
    tx_answer_a: assert property (tx_ts0_req_i |=> tx_ts0_valid_o) else $error("transmit byte missing");
    tx_mf_flag_a: assert property (tx_ts0_req_i && tx_frame_num_i == FRAME_FIRST |=> tx_multiframe_flag_o ##1
        !tx_multiframe_flag_o || $past(tx_ts0_req_i)) else $error("transmit flag wrong");
    tx_keep_base_a: assert property (tx_ts0_req_i |=> ((tx_ts0_o ^ $past(tx_ts0_base_i)) & $past(keep)) == 8'h00)
        else $error("disabled group not passed through");
endmodule
bind esm_regs esm_regs_checker chk_u (.clk_sys_i, .sys_rst_i, .host_addr_i, .host_wr_i, .host_rd_i, .host_wdata_i,
    .host_rdata_o, .host_rvalid_o, .rx_ts0_valid_i, .rx_frame_num_i, .rx_multiframe_flag_o, .tx_ts0_req_i,
    .tx_frame_num_i, .tx_ts0_base_i, .tx_ts0_o, .tx_ts0_valid_o, .tx_multiframe_flag_o);
`default_nettype wire

// [tb/tb.sv]
// Self-checking testbench for the spare bit register set.
`timescale 1ns/1ps
`default_nettype none
module tb
    import esm_pkg::*;
;
    logic       clk_sys_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic [7:0] host_addr_i;
    logic [7:0] host_wdata_i;
    logic [7:0] host_rdata_o;
    logic       host_wr_i;
    logic       host_rd_i;
    logic       host_rvalid_o;
    logic       rx_ts0_valid_i = 1'b0;
    logic [3:0] rx_frame_num_i = 4'h0;
    logic [7:0] rx_ts0_i = 8'h00;
    logic       rx_multiframe_flag_o;
    logic       tx_ts0_req_i = 1'b0;
    logic [3:0] tx_frame_num_i = 4'h0;
    logic [7:0] tx_ts0_base_i = 8'h00;
    logic [7:0] tx_ts0_o;
    logic       tx_ts0_valid_o;
    logic       tx_multiframe_flag_o;
    int         mismatches = 0;
    int         compares = 0;
    int         p;
    logic [7:0] b;
    logic [7:0] d;
    logic       v;
    logic [7:0] treg [0:8];
    logic [7:0] samp [0:7];
    logic [7:0] rexp [0:7] = '{default: 8'h00};
    always #5 clk_sys_i = ~clk_sys_i;
    esm_regs dut_u (.clk_sys_i, .sys_rst_i, .host_addr_i, .host_wr_i, .host_rd_i, .host_wdata_i, .host_rdata_o,
        .host_rvalid_o, .rx_ts0_valid_i, .rx_frame_num_i, .rx_ts0_i, .rx_multiframe_flag_o, .tx_ts0_req_i,
        .tx_frame_num_i, .tx_ts0_base_i, .tx_ts0_o, .tx_ts0_valid_o, .tx_multiframe_flag_o);
    esm_host_model host_u (.clk_sys_i, .host_addr_o(host_addr_i), .host_wr_o(host_wr_i), .host_rd_o(host_rd_i),
        .host_wdata_o(host_wdata_i), .host_rdata_i(host_rdata_o), .host_rvalid_i(host_rvalid_o));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a, d, v);
        chk("read valid", 8'h01, {7'h00, v});
        chk($sformatf("register %h", a), e, d);
    endtask
    task automatic rx_frame(input logic [3:0] f, input logic [7:0] x);
        @(negedge clk_sys_i);
        rx_ts0_valid_i = 1'b1;
        rx_frame_num_i = f;
        rx_ts0_i = x;
        @(negedge clk_sys_i);
        rx_ts0_valid_i = 1'b0;
        rx_ts0_i = ~x;
        chk("rx flag", {7'h00, f == FRAME_LAST}, {7'h00, rx_multiframe_flag_o});
    endtask
    task automatic tx_frame(input logic [3:0] f, input logic [7:0] base, input logic [7:0] c);
        logic [7:0] e;
        int         q;
        if (f == FRAME_FIRST)
            for (int i = 0; i < 8; i++)
                samp[i] = treg[i];
        e = base;
        q = 7 - f / 2;
        if (!f[0] && c[7])
            e[7] = samp[0][q];
        if (f[0] && c[6])
            e[7] = samp[1][q];
        for (int j = 0; j < 6; j++)
            if (f[0] && c[j])
                e[j] = samp[7 - j][q];
        @(negedge clk_sys_i);
        tx_ts0_req_i = 1'b1;
        tx_frame_num_i = f;
        tx_ts0_base_i = base;
        @(negedge clk_sys_i);
        tx_ts0_req_i = 1'b0;
        tx_ts0_base_i = ~base;
        chk("tx valid", 8'h01, {7'h00, tx_ts0_valid_o});
        chk("tx flag", {7'h00, f == FRAME_FIRST}, {7'h00, tx_multiframe_flag_o});
        chk("tx byte", e, tx_ts0_o);
    endtask
    task automatic end_of_test();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        mismatches++;
        end_of_test();
    end
    initial
    begin
        repeat (4) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        for (int a = 8'hc8; a <= 8'hdf; a++)
            rchk(a[7:0], 8'h00);
        for (int i = 0; i < 9; i++)
        begin
            treg[i] = 8'h96 ^ {i[3:0], ~i[3:0]};
            host_u.wr(TX_INTL_ALIGN_OFS + i[7:0], treg[i]);
        end
        host_u.wr(RX_SPARE6_OFS, 8'hff);
        host_u.wr(8'hdf, 8'hff);
        for (int i = 0; i < 9; i++)
            rchk(TX_INTL_ALIGN_OFS + i[7:0], treg[i]);
        rchk(RX_SPARE6_OFS, 8'h00);
        rchk(8'hdf, 8'h00);
        // Receive multiframe; registers stay old until the last frame publishes.
        for (int f = 0; f < 16; f++)
        begin
            b = 8'h3c ^ {f[3:0], ~f[3:0]};
            p = 7 - f / 2;
            if (f % 2 == 0)
                rexp[0][p] = b[7];
            else
                rexp[1][p] = b[7];
            for (int j = 0; j < 6; j++)
                if (f % 2 == 1)
                    rexp[7 - j][p] = b[j];
            if (f == 15)
                rchk(RX_SPARE6_OFS, 8'h00);
            rx_frame(f[3:0], b);
        end
        for (int i = 0; i < 8; i++)
            rchk(RX_INTL_ALIGN_OFS + i[7:0], rexp[i]);
        // Transmit multiframes; a mid-multiframe update only shows from the next frame 0.
        foreach (samp[i])
            samp[i] = 8'h00;
        for (int k = 0; k < 5; k++)
        begin
            treg[8] = (k == 4) ? 8'h00 : {4{k[0], k[1]}} | {8{k[1] & k[0]}};
            host_u.wr(TX_INSERT_CTRL_OFS, treg[8]);
            for (int f = 0; f < 16; f++)
            begin
                tx_frame(f[3:0], 8'hc3 ^ {f[3:0], f[3:0]}, treg[8]);
                if (f == 7)
                    for (int i = 0; i < 8; i++)
                    begin
                        treg[i] = ~treg[i] ^ k[7:0];
                        host_u.wr(TX_INTL_ALIGN_OFS + i[7:0], treg[i]);
                    end
            end
        end
        // Reset in mid-run returns every register to zero.
        @(negedge clk_sys_i);
        sys_rst_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        for (int a = 8'hc8; a <= 8'hda; a++)
            rchk(a[7:0], 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
